// ==== core/ccs_defs.vh ====
`ifndef CCS_DEFS_VH
`define CCS_DEFS_VH
// ****************************************
// opcodes
// ****************************************
`define CCS_OP_CARRY_FORCE  8'hDF
`define CCS_OP_SHIFT_R      8'hD0
`define CCS_OP_SHIFT_IR     8'hD1
`define CCS_OP_PTR_LOAD     8'h31
`define CCS_OP_STOP         8'h7F
`define CCS_OP_SUB_RR       8'h22
`define CCS_OP_SUB_RIR      8'h23
`define CCS_OP_SUB_GG       8'h24
`define CCS_OP_SUB_GIG      8'h25
`define CCS_OP_SUB_GIM      8'h26
// ****************************************
// flag bit positions
// ****************************************
`define CCS_FLG_C           7
`define CCS_FLG_Z           6
`define CCS_FLG_S           5
`define CCS_FLG_V           4
`define CCS_FLG_D           3
`define CCS_FLG_H           2
`define CCS_FLAGS_RESET     8'h00
// ****************************************
// register file locations
// ****************************************
`define CCS_ADDR_PTR0       8'hD6
`define CCS_ADDR_PTR1       8'hD7
`define CCS_RF_RESET        8'h00
`define CCS_WORK_NIB        4'hC
// ****************************************
// pointer-load selector patterns
// ****************************************
`define CCS_SEL_PTR0        2'h2
`define CCS_SEL_PTR1        2'h1
`define CCS_SEL_BOTH        2'h0
// ****************************************
// cycle counts
// ****************************************
`define CCS_CYC_SHORT       4'h4
`define CCS_CYC_LONG        4'h6
`endif

// ==== core/ccs_alu.v ====
`timescale 1ns/100ps
`include "ccs_defs.vh"
// ****************************************
// subtract and arithmetic shift datapath
// ****************************************
module ccs_alu (
  input  wire       do_sub,
  input  wire [7:0] dst_val,
  input  wire [7:0] src_val,
  input  wire [7:0] flags_in,
  output reg  [7:0] result,
  output reg  [7:0] flags_out
);
  reg [8:0] sum;
  reg [4:0] low;

  always @* begin
    flags_out = flags_in;
    sum       = 9'h000;
    low       = 5'h00;
    if (do_sub) begin
      // two's complement add of the source
      sum    = {1'b0, dst_val} + {1'b0, ~src_val} + 9'h001;
      low    = {1'b0, dst_val[3:0]} + {1'b0, ~src_val[3:0]} + 5'h01;
      result = sum[7:0];
      flags_out[`CCS_FLG_C] = ~sum[8];
      flags_out[`CCS_FLG_V] = (dst_val[7] != src_val[7]) &&
                              (result[7] == src_val[7]);
      flags_out[`CCS_FLG_D] = 1'b1;
      flags_out[`CCS_FLG_H] = ~low[4];
    end else begin
      result = {dst_val[7], dst_val[7:1]};
      flags_out[`CCS_FLG_C] = dst_val[0];
      flags_out[`CCS_FLG_V] = 1'b0;
    end
    flags_out[`CCS_FLG_Z] = (result == 8'h00);
    flags_out[`CCS_FLG_S] = result[7];
  end
endmodule // ccs_alu

// ==== core/ccs_core.v ====
`timescale 1ns/100ps
`include "ccs_defs.vh"
module ccs_core (
  input  wire       mclk,
  input  wire       rst_n,
  input  wire       instr_valid,
  input  wire [7:0] instr_op,
  input  wire [7:0] instr_b1,
  input  wire [7:0] instr_b2,
  output reg        instr_ready,
  output reg        instr_done,
  output reg  [7:0] flags,
  output reg        stop_mode,
  output reg        clk_run,
  input  wire       ext_int,
  input  wire       host_we,
  input  wire [7:0] host_addr,
  input  wire [7:0] host_wdata,
  output reg  [7:0] host_rdata,
  output reg  [7:0] window_pointer_zero,
  output reg  [7:0] window_pointer_one
);
  // ****************************************
  // states
  // ****************************************
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_EXEC = 3'h2;
  localparam [2:0] ST_STOP = 3'h4;

  reg [2:0] state;
  reg [3:0] cnt;
  reg [7:0] op;
  reg [7:0] b1;
  reg [7:0] b2;
  reg [7:0] rf [0:255];
  reg       int_s1;
  reg       int_s2;
  reg       int_s3;

  wire [7:0] rp0 = rf[`CCS_ADDR_PTR0];
  wire [7:0] rp1 = rf[`CCS_ADDR_PTR1];

  // ****************************************
  // helpers
  // ****************************************
  function [7:0] resolve;
    input [7:0] a;
    input [7:0] p0;
    input [7:0] p1;
    begin
      if (a[7:4] == `CCS_WORK_NIB)
        resolve = a[3] ? {p1[7:3], a[2:0]} : {p0[7:3], a[2:0]};
      else
        resolve = a;
    end
  endfunction

  function [3:0] op_cycles;
    input [7:0] o;
    begin
      case (o)
        `CCS_OP_SUB_RIR, `CCS_OP_SUB_GG,
        `CCS_OP_SUB_GIG, `CCS_OP_SUB_GIM: op_cycles = `CCS_CYC_LONG;
        default:                          op_cycles = `CCS_CYC_SHORT;
      endcase
    end
  endfunction

  // ****************************************
  // operand decode
  // ****************************************
  reg  [7:0] dst_addr;
  reg  [7:0] src_val;
  reg        alu_we;
  wire [7:0] alu_res;
  wire [7:0] alu_flags;
  wire       is_sub = (op[7:4] == 4'h2);
  wire       commit = (state == ST_EXEC) && (cnt == 4'h1);

  always @* begin
    dst_addr = 8'h00;
    src_val  = 8'h00;
    alu_we   = 1'b0;
    case (op)
      `CCS_OP_SUB_RR: begin
        dst_addr = resolve({`CCS_WORK_NIB, b1[7:4]}, rp0, rp1);
        src_val  = rf[resolve({`CCS_WORK_NIB, b1[3:0]}, rp0, rp1)];
        alu_we   = 1'b1;
      end
      `CCS_OP_SUB_RIR: begin
        dst_addr = resolve({`CCS_WORK_NIB, b1[7:4]}, rp0, rp1);
        src_val  = rf[rf[resolve({`CCS_WORK_NIB, b1[3:0]}, rp0, rp1)]];
        alu_we   = 1'b1;
      end
      `CCS_OP_SUB_GG: begin
        dst_addr = resolve(b2, rp0, rp1);
        src_val  = rf[resolve(b1, rp0, rp1)];
        alu_we   = 1'b1;
      end
      `CCS_OP_SUB_GIG: begin
        dst_addr = resolve(b2, rp0, rp1);
        src_val  = rf[rf[resolve(b1, rp0, rp1)]];
        alu_we   = 1'b1;
      end
      `CCS_OP_SUB_GIM: begin
        dst_addr = resolve(b1, rp0, rp1);
        src_val  = b2;
        alu_we   = 1'b1;
      end
      `CCS_OP_SHIFT_R: begin
        dst_addr = resolve(b1, rp0, rp1);
        alu_we   = 1'b1;
      end
      `CCS_OP_SHIFT_IR: begin
        dst_addr = rf[resolve(b1, rp0, rp1)];
        alu_we   = 1'b1;
      end
      default: begin
        dst_addr = 8'h00;
      end
    endcase
  end

  ccs_alu u_alu (
    .do_sub    (is_sub),
    .dst_val   (rf[dst_addr]),
    .src_val   (src_val),
    .flags_in  (flags),
    .result    (alu_res),
    .flags_out (alu_flags)
  );

  // ****************************************
  // pointer load
  // ****************************************
  reg [7:0] next_rp0;
  reg [7:0] next_rp1;
  reg       ptr_we0;
  reg       ptr_we1;

  always @* begin
    next_rp0 = rp0;
    next_rp1 = rp1;
    ptr_we0  = 1'b0;
    ptr_we1  = 1'b0;
    if (commit && op == `CCS_OP_PTR_LOAD) begin
      case (b1[1:0])
        `CCS_SEL_PTR0: begin
          next_rp0 = {b1[7:3], rp0[2:0]};
          ptr_we0  = 1'b1;
        end
        `CCS_SEL_PTR1: begin
          next_rp1 = {b1[7:3], rp1[2:0]};
          ptr_we1  = 1'b1;
        end
        `CCS_SEL_BOTH: begin
          next_rp0 = {b1[7:4], 1'b0, rp0[2:0]};
          next_rp1 = {b1[7:4], 1'b1, rp1[2:0]};
          ptr_we0  = 1'b1;
          ptr_we1  = 1'b1;
        end
        default: begin
          ptr_we0  = 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // register file
  // ****************************************
  wire alu_wr  = commit && alu_we;
  wire host_wr = host_we && (state != ST_STOP);

  genvar gi;
  generate
    for (gi = 0; gi < 256; gi = gi + 1) begin : g_rf
      localparam [7:0] IDX = gi;
      always @(posedge mclk) begin
        if (!rst_n)
          rf[gi] <= `CCS_RF_RESET;
        else if (alu_wr && dst_addr == IDX)
          rf[gi] <= alu_res;
        else if (ptr_we0 && IDX == `CCS_ADDR_PTR0)
          rf[gi] <= next_rp0;
        else if (ptr_we1 && IDX == `CCS_ADDR_PTR1)
          rf[gi] <= next_rp1;
        else if (host_wr && host_addr == IDX)
          rf[gi] <= host_wdata;
      end
    end
  endgenerate

  // ****************************************
  // wake-up input synchroniser
  // ****************************************
  always @(posedge mclk) begin
    if (!rst_n) begin
      int_s1 <= 1'b0;
      int_s2 <= 1'b0;
      int_s3 <= 1'b0;
    end else begin
      int_s1 <= ext_int;
      int_s2 <= int_s1;
      int_s3 <= int_s2;
    end
  end

  wire wake = int_s2 && int_s3;

  // ****************************************
  // sequencer
  // ****************************************
  always @(posedge mclk) begin
    if (!rst_n) begin
      state       <= ST_IDLE;
      cnt         <= 4'h0;
      op          <= 8'h00;
      b1          <= 8'h00;
      b2          <= 8'h00;
      instr_ready <= 1'b0;
      instr_done  <= 1'b0;
      flags       <= `CCS_FLAGS_RESET;
      stop_mode   <= 1'b0;
      clk_run     <= 1'b1;
    end else begin
      instr_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          instr_ready <= 1'b1;
          if (instr_valid && instr_ready) begin
            op          <= instr_op;
            b1          <= instr_b1;
            b2          <= instr_b2;
            cnt         <= op_cycles(instr_op) - 4'h1;
            instr_ready <= 1'b0;
            state       <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          cnt <= cnt - 4'h1;
          if (cnt == 4'h1) begin
            instr_done <= 1'b1;
            if (alu_we)
              flags <= alu_flags;
            else if (op == `CCS_OP_CARRY_FORCE)
              flags[`CCS_FLG_C] <= 1'b1;
            if (op == `CCS_OP_STOP) begin
              stop_mode <= 1'b1;
              clk_run   <= 1'b0;
              state     <= ST_STOP;
            end else begin
              instr_ready <= 1'b1;
              state       <= ST_IDLE;
            end
          end
        end
        ST_STOP: begin
          if (wake) begin
            stop_mode   <= 1'b0;
            clk_run     <= 1'b1;
            instr_ready <= 1'b1;
            state       <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // registered observation outputs
  // ****************************************
  always @(posedge mclk) begin
    if (!rst_n) begin
      host_rdata          <= 8'h00;
      window_pointer_zero <= `CCS_RF_RESET;
      window_pointer_one  <= `CCS_RF_RESET;
    end else begin
      host_rdata          <= rf[host_addr];
      window_pointer_zero <= rp0;
      window_pointer_one  <= rp1;
    end
  end
endmodule // ccs_core

// ==== tb/ccs_core_asserts.sv ====
`timescale 1ns/100ps
// ******
// checker
// ******
module ccs_core_asserts (
  input wire       mclk,
  input wire       rst_n,
  input wire       instr_valid,
  input wire [7:0] instr_op,
  input wire       instr_ready,
  input wire       instr_done,
  input wire [7:0] flags,
  input wire       stop_mode,
  input wire       clk_run,
  input wire       ext_int,
  input wire       host_we,
  input wire [7:0] host_addr,
  input wire [7:0] host_wdata,
  input wire [7:0] window_pointer_zero,
  input wire [7:0] window_pointer_one
);
  wire take;
  assign take = instr_valid && instr_ready;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_carry_force:
    assert property (take && instr_op == 8'hDF |-> ##4 instr_done
      && flags == ($past(flags, 4) | 8'h80)) else $error("carry force");
  a_shift_flags:
    assert property (take && (instr_op == 8'hD0 || instr_op == 8'hD1)
      |-> ##4 instr_done && !flags[4] && flags[3:2] == $past(flags[3:2], 4))
      else $error("shift flags");
  a_sub_short:
    assert property (take && instr_op == 8'h22 |-> ##4 instr_done && flags[3])
      else $error("short subtract");
  a_sub_long:
    assert property (take && instr_op > 8'h22 && instr_op < 8'h27
      |-> ##6 instr_done && flags[3]) else $error("long subtract");
  a_stop_enter:
    assert property (take && instr_op == 8'h7F |-> ##4 instr_done
      && stop_mode && !clk_run && flags == $past(flags, 4))
      else $error("stop entry");
  a_stop_keep:
    assert property (stop_mode |=> $stable(flags)
      && $stable(window_pointer_zero) && $stable(window_pointer_one))
      else $error("state lost in stop");
  a_stop_exit:
    assert property (stop_mode ##1 !stop_mode |-> $past(ext_int, 1)
      || $past(ext_int, 2) || $past(ext_int, 3) || $past(ext_int, 4))
      else $error("stop left without wake");
  a_ptr_mirror:
    assert property (host_we && instr_ready && !stop_mode
      && host_addr == 8'hD6 |-> ##2 window_pointer_zero
      == $past(host_wdata, 2)) else $error("pointer zero location");
endmodule // ccs_core_asserts

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin \
  n_mismatch++; $display("Error %s exp %h got %h", n, e, s); end end
// ******
// bench
// ******
module tb_top;
  reg       mclk, rst_n, instr_valid, ext_int, host_we, rv, rv_q;
  reg [7:0] instr_op, instr_b1, instr_b2, host_addr, host_wdata;
  reg [7:0] ef, ev, a, b, ra_q;
  reg [7:0] fq[$], rq[$], sq[$];
  wire      instr_ready, instr_done, stop_mode, clk_run;
  wire [7:0] flags, host_rdata, wp0, wp1;
  int       n_mismatch, comparisons, i;
  ccs_core u_ccs_core (.mclk(mclk), .rst_n(rst_n),
    .instr_valid(instr_valid), .instr_op(instr_op), .instr_b1(instr_b1),
    .instr_b2(instr_b2), .instr_ready(instr_ready), .instr_done(instr_done),
    .flags(flags), .stop_mode(stop_mode), .clk_run(clk_run),
    .ext_int(ext_int), .host_we(host_we), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata),
    .window_pointer_zero(wp0), .window_pointer_one(wp1));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    rv_q <= rv;
    ra_q <= host_addr;
  end
  always @(negedge mclk) begin
    if (instr_done) begin
      ev = fq.pop_front();
      `CHK("flags", ev, flags)
      ev = sq.pop_front();
      `CHK("stop", ev, {6'h00, stop_mode, clk_run})
    end
    if (rv_q) begin
      ev = rq.pop_front();
      `CHK("rdata", ev, host_rdata)
      if (ra_q == 8'hD6) `CHK("wp0", ev, wp0)
      if (ra_q == 8'hD7) `CHK("wp1", ev, wp1)
    end
  end
  task results;
    begin
      if (n_mismatch == 0 && comparisons > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task idle;
    begin
      @(negedge mclk);
      while (!instr_ready) @(negedge mclk);
    end
  endtask
  task ex(input [7:0] op, input [7:0] b1, input [7:0] b2);
    begin
      idle;
      fq.push_back(ef);
      sq.push_back({6'h00, op == 8'h7F, op != 8'h7F});
      instr_valid = 1'b1;
      instr_op = op;
      instr_b1 = b1;
      instr_b2 = b2;
      @(negedge mclk);
      instr_valid = 1'b0;
    end
  endtask
  task wr(input [7:0] ad, input [7:0] d);
    begin
      idle;
      host_we = 1'b1;
      host_addr = ad;
      host_wdata = d;
      @(negedge mclk);
      host_we = 1'b0;
    end
  endtask
  task rd(input [7:0] ad, input [7:0] e);
    begin
      idle;
      host_addr = ad;
      rq.push_back(e);
      rv = 1'b1;
      @(negedge mclk);
      rv = 1'b0;
    end
  endtask
  task arith_shift_right_op(input [7:0] op, input [7:0] v);
    reg [7:0] r;
    begin
      r = {v[7], v[7:1]};
      wr(8'h10, v);
      wr(8'h11, 8'h12);
      wr(8'h12, v);
      ef = {v[0], r == 8'h00, r[7], 1'b0, ef[3:2], 2'b00};
      ex(op, op == 8'hD0 ? 8'h10 : 8'h11, 8'h00);
      rd(op == 8'hD0 ? 8'h10 : 8'h12, r);
    end
  endtask
  task sub(input [7:0] op, input [7:0] x, input [7:0] y);
    reg [7:0] r;
    begin
      r = x - y;
      wr(8'h51, x);
      wr(8'h6A, op == 8'h22 ? y : 8'h20);
      wr(8'h20, y);
      ef = {x < y, r == 8'h00, r[7], x[7] != y[7] && r[7] == y[7], 1'b1,
        x[3:0] < y[3:0], 2'b00};
      ex(op, op == 8'h24 ? 8'h20 : op == 8'h25 ? 8'h6A :
        op == 8'h26 ? 8'h51 : 8'h1A, op == 8'h26 ? y : 8'h51);
      rd(8'h51, r);
      rd(8'h20, y);
    end
  endtask
  initial begin
    {rst_n, instr_valid, ext_int, host_we, rv} = 5'h00;
    {instr_op, instr_b1, instr_b2, host_addr, host_wdata} = 40'h0;
    ef = 8'h00;
    n_mismatch = 0;
    comparisons = 0;
    void'($urandom(57330));
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    rd(8'hD6, 8'h00);
    wr(8'hD6, 8'h07);
    ex(8'h31, 8'h40, 8'h00);
    rd(8'hD6, 8'h47);
    rd(8'hD7, 8'h48);
    ex(8'h31, 8'h52, 8'h00);
    ex(8'h31, 8'h69, 8'h00);
    ex(8'h31, 8'h73, 8'h00);
    rd(8'hD6, 8'h57);
    rd(8'hD7, 8'h68);
    arith_shift_right_op(8'hD0, 8'h9A);
    ef = ef | 8'h80;
    ex(8'hDF, 8'h00, 8'h00);
    for (i = 0; i < 6; i++) arith_shift_right_op(i[0] ? 8'hD1 : 8'hD0,
      i < 2 ? 8'h01 : 8'($urandom));
    for (i = 0; i < 15; i++) begin
      a = i < 5 ? 8'h21 : 8'($urandom);
      b = i < 5 ? 8'h90 : 8'($urandom);
      sub(8'h22 + 8'(i % 5), a, b);
    end
    ex(8'hFF, 8'h00, 8'h00);
    wr(8'h30, 8'h5A);
    ex(8'h7F, 8'h00, 8'h00);
    repeat (8) @(negedge mclk);
    host_we = 1'b1;
    host_addr = 8'h30;
    host_wdata = 8'h00;
    @(negedge mclk);
    host_we = 1'b0;
    ext_int = 1'b1;
    idle;
    ext_int = 1'b0;
    rd(8'h30, 8'h5A);
    ex(8'h7F, 8'h00, 8'h00);
    repeat (8) @(negedge mclk);
    rst_n = 1'b0;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    ef = 8'h00;
    rd(8'h30, 8'h00);
    results;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    results;
  end
endmodule // tb_top
bind ccs_core ccs_core_asserts u_ccs_core_asserts (.mclk(mclk),
  .rst_n(rst_n), .instr_valid(instr_valid), .instr_op(instr_op),
  .instr_ready(instr_ready), .instr_done(instr_done), .flags(flags),
  .stop_mode(stop_mode), .clk_run(clk_run), .ext_int(ext_int),
  .host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata),
  .window_pointer_zero(window_pointer_zero),
  .window_pointer_one(window_pointer_one));
